// [rtb_pkg.sv]
package rtb_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ACCESS_KEY     = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ENABLE     = 8'h28;
  localparam logic [7:0] ADDR_IRQ_STATUS     = 8'h2C;
  localparam logic [7:0] ADDR_TICK_SELECT    = 8'h30;
  localparam logic [7:0] ADDR_BACKUP_CONTROL = 8'h3C;
  localparam logic [7:0] ADDR_BACKUP_FIRST   = 8'h40;
  localparam logic [7:0] ADDR_BACKUP_LAST    = 8'h8C;

  // ----------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------
  localparam int          BACKUP_WORDS     = 20;
  localparam logic [15:0] ACCESS_KEY       = 16'hA965;
  localparam int          POS_GRANTED      = 16;
  localparam int          POS_TICK_IRQ     = 1;
  localparam int          POS_BANK_ENABLE  = 2;
  localparam int          POS_UPDATE_READY = 7;
  localparam logic [31:0] RESET_TICK_SELECT = 32'h0000_0000;
  localparam logic [31:0] RESET_BACKUP_CTRL = 32'h0000_0080;
  localparam logic [31:0] RESET_BACKUP_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ          = 40_000_000;
  localparam int TICK_BASE_SECONDS = 1;
  localparam int TICK_SECOND_CYCLES = CLOCK_HZ * TICK_BASE_SECONDS;
  localparam int TICK_SUBSTEPS     = 128;
  localparam logic [2:0] UPDATE_CYCLES = 3'h4;

  typedef struct packed {
    logic       granted;
    logic [2:0] tick_sel;
    logic       bank_enable;
    logic       tick_irq_enable;
    logic       tick_flag;
  } rtb_ctrl_type;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ_WAIT
  } rtb_bus_state_type;

endpackage

// [rtb_top.sv]
// Contract
// - Selector codes 000, 001, 010 and 011 give tick periods of 1, 1/2, 1/4 and 1/8 second.
// - Selector code 110 gives a tick period of 1/64 second.
// - The selector reads back only while access is granted and reads zero otherwise.
// - The update-ready bit reads low while a control or backup-word write settles, high after.
// - The update-ready bit is read only and writes to it have no effect.
// - Bit 2 of the backup control register enables the backup words.
// - While the bank is disabled, reads and writes of the twenty backup words are blocked.
// - The backup control register resets to 0x0000_0080.
// - Writing key 0xA965 to the low half of the key register sets the access-granted flag at bit 16.
// - Each elapsed tick sets the tick flag, which raises the interrupt when enabled and clears on write one.
// - Each backup word is 32-bit read/write storage; a write also holds the update-ready bit low while it settles.
`timescale 1ns/1ps
`default_nettype none

module rtb_top
  import rtb_pkg::*;
#(
  parameter int TICK_BASE_CYCLES = TICK_SECOND_CYCLES / TICK_SUBSTEPS
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output var  logic [31:0] hrdata_o,
  output var  logic        hreadyout_o,
  output var  logic        hresp_o,
  output var  logic        irq_o
);

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_backup(input logic [7:0] addr);
    is_backup = (addr >= ADDR_BACKUP_FIRST) && (addr <= ADDR_BACKUP_LAST) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] backup_index(input logic [7:0] addr);
    logic [7:0] off;
    off = addr - ADDR_BACKUP_FIRST;
    backup_index = off[6:2];
  endfunction

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_ACCESS_KEY,
    SEL_IRQ_ENABLE,
    SEL_IRQ_STATUS,
    SEL_TICK_SELECT,
    SEL_BACKUP_CONTROL,
    SEL_BACKUP_WORD
  } rtb_reg_sel_type;

  // One decode serves the read and the write path, so the two can never disagree on the map.
  function automatic rtb_reg_sel_type reg_select(input logic [7:0] addr);
    if (addr == ADDR_ACCESS_KEY) begin
      reg_select = SEL_ACCESS_KEY;
    end else if (addr == ADDR_IRQ_ENABLE) begin
      reg_select = SEL_IRQ_ENABLE;
    end else if (addr == ADDR_IRQ_STATUS) begin
      reg_select = SEL_IRQ_STATUS;
    end else if (addr == ADDR_TICK_SELECT) begin
      reg_select = SEL_TICK_SELECT;
    end else if (addr == ADDR_BACKUP_CONTROL) begin
      reg_select = SEL_BACKUP_CONTROL;
    end else if (is_backup(addr)) begin
      reg_select = SEL_BACKUP_WORD;
    end else begin
      reg_select = SEL_NONE;
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rtb_bus_state_type bus_state;
  rtb_bus_state_type next_bus_state;
  logic [7:0]        bus_addr;
  logic [7:0]        next_bus_addr;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic              ready;
  logic              next_ready;
  logic              resp;
  logic              next_resp;

  rtb_ctrl_type      ctrl;
  rtb_ctrl_type      next_ctrl;
  logic [31:0]       backup_mem [BACKUP_WORDS];
  logic              backup_write;
  logic [2:0]        settle_count;
  logic [2:0]        next_settle_count;
  logic              irq;
  logic              next_irq;

  logic [31:0]       base_count;
  logic [31:0]       next_base_count;
  logic [6:0]        sub_count;
  logic [6:0]        next_sub_count;
  logic              tick_pulse;
  logic              next_tick_pulse;

  logic              accept;
  logic              write_commit;
  logic              update_ready;
  logic [6:0]        tick_mask;
  logic              base_pulse;
  rtb_reg_sel_type   bus_sel;

  assign accept       = hsel_i && htrans_i[1] && hready_i;
  assign bus_sel      = reg_select(bus_addr);
  assign write_commit = (bus_state == BUS_WRITE);
  assign update_ready = (settle_count == 3'h0);
  assign backup_write = write_commit && (bus_sel == SEL_BACKUP_WORD) && ctrl.bank_enable;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_comb begin
    next_bus_state = bus_state;
    next_bus_addr  = bus_addr;
    next_rdata     = rdata;
    next_ready     = 1'b1;
    next_resp      = 1'b0;
    case (bus_state)
      BUS_READ_WAIT: begin
        next_rdata     = 32'h0000_0000;
        next_bus_state = BUS_IDLE;
        case (bus_sel)
          SEL_ACCESS_KEY: begin
            next_rdata[POS_GRANTED] = ctrl.granted;
          end
          SEL_IRQ_ENABLE: begin
            next_rdata[POS_TICK_IRQ] = ctrl.tick_irq_enable;
          end
          SEL_IRQ_STATUS: begin
            next_rdata[POS_TICK_IRQ] = ctrl.tick_flag;
          end
          SEL_TICK_SELECT: begin
            if (ctrl.granted) begin
              next_rdata[2:0] = ctrl.tick_sel;
            end
          end
          SEL_BACKUP_CONTROL: begin
            next_rdata[POS_UPDATE_READY] = update_ready;
            next_rdata[POS_BANK_ENABLE]  = ctrl.bank_enable;
          end
          SEL_BACKUP_WORD: begin
            if (ctrl.bank_enable) begin
              next_rdata = backup_mem[backup_index(bus_addr)];
            end
          end
          default: begin
            next_rdata = 32'h0000_0000;
          end
        endcase
      end
      default: begin
        next_bus_state = BUS_IDLE;
        if (accept) begin
          next_bus_addr = haddr_i[7:0];
          if (hwrite_i) begin
            next_bus_state = BUS_WRITE;
          end else begin
            next_bus_state = BUS_READ_WAIT;
            next_ready     = 1'b0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_state <= BUS_IDLE;
      bus_addr  <= 8'h00;
      rdata     <= 32'h0000_0000;
      ready     <= 1'b1;
      resp      <= 1'b0;
    end else begin
      bus_state <= next_bus_state;
      bus_addr  <= next_bus_addr;
      rdata     <= next_rdata;
      ready     <= next_ready;
      resp      <= next_resp;
    end
  end

  // ----------------------------------------------------------------
  // Tick generator
  // ----------------------------------------------------------------
  assign base_pulse = (base_count == 32'(TICK_BASE_CYCLES - 1));
  assign tick_mask  = 7'h7F >> ctrl.tick_sel;

  always_comb begin
    next_base_count = base_pulse ? 32'h0000_0000 : base_count + 32'h0000_0001;
    next_sub_count  = base_pulse ? sub_count + 7'h01 : sub_count;
    next_tick_pulse = base_pulse && ((sub_count & tick_mask) == tick_mask);
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      base_count <= 32'h0000_0000;
      sub_count  <= 7'h00;
      tick_pulse <= 1'b0;
    end else begin
      base_count <= next_base_count;
      sub_count  <= next_sub_count;
      tick_pulse <= next_tick_pulse;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_comb begin
    next_ctrl         = ctrl;
    next_settle_count = (settle_count != 3'h0) ? settle_count - 3'h1 : 3'h0;
    if (write_commit) begin
      case (bus_sel)
        SEL_ACCESS_KEY: begin
          next_ctrl.granted = (hwdata_i[15:0] == ACCESS_KEY);
        end
        SEL_IRQ_ENABLE: begin
          next_ctrl.tick_irq_enable = hwdata_i[POS_TICK_IRQ];
        end
        SEL_IRQ_STATUS: begin
          if (hwdata_i[POS_TICK_IRQ]) begin
            next_ctrl.tick_flag = 1'b0;
          end
        end
        SEL_TICK_SELECT: begin
          if (ctrl.granted) begin
            next_ctrl.tick_sel = hwdata_i[2:0];
          end
        end
        SEL_BACKUP_CONTROL: begin
          if (ctrl.granted) begin
            next_ctrl.bank_enable = hwdata_i[POS_BANK_ENABLE];
            next_settle_count     = UPDATE_CYCLES;
          end
        end
        SEL_BACKUP_WORD: begin
          if (ctrl.bank_enable) begin
            next_settle_count = UPDATE_CYCLES;
          end
        end
        default: begin
          next_ctrl = ctrl;
        end
      endcase
    end
    // The set comes after the clear so that a tick landing with a clear is never lost.
    if (tick_pulse) begin
      next_ctrl.tick_flag = 1'b1;
    end
    next_irq = next_ctrl.tick_flag && next_ctrl.tick_irq_enable;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl.granted         <= 1'b0;
      ctrl.tick_sel        <= RESET_TICK_SELECT[2:0];
      ctrl.bank_enable     <= RESET_BACKUP_CTRL[POS_BANK_ENABLE];
      ctrl.tick_irq_enable <= 1'b0;
      ctrl.tick_flag       <= 1'b0;
      settle_count         <= 3'h0;
      irq                  <= 1'b0;
    end else begin
      ctrl         <= next_ctrl;
      settle_count <= next_settle_count;
      irq          <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Backup words
  // ----------------------------------------------------------------
  for (genvar g = 0; g < BACKUP_WORDS; g++) begin : gen_word
    logic [31:0] next_word;

    always_comb begin
      next_word = backup_mem[g];
      if (backup_write && (backup_index(bus_addr) == 5'(g))) begin
        next_word = hwdata_i;
      end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        backup_mem[g] <= RESET_BACKUP_WORD;
      end else begin
        backup_mem[g] <= next_word;
      end
    end
  end

  assign hrdata_o    = rdata;
  assign hreadyout_o = ready;
  assign hresp_o     = resp;
  assign irq_o       = irq;

endmodule

`default_nettype wire

// [rtb_checker.sv]
`timescale 1ns/1ps
`default_nettype none

module rtb_checker
  import rtb_pkg::*;
#(
  parameter int TICK_BASE_CYCLES = 4
) (
  input wire logic        clock_i,
  input wire logic        rst_n_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        irq_o
);
  logic take;
  logic rd_take;
  logic wr_take;
  assign take    = hsel_i & htrans_i[1] & hready_i;
  assign rd_take = take & ~hwrite_i;
  assign wr_take = take & hwrite_i;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_read_wait: assert property (rd_take |-> ##1 !hreadyout_o ##1 hreadyout_o)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (wr_take |-> ##1 hreadyout_o)
    else $error("write stalled");
  chk_data_hold: assert property (hreadyout_o && $past(hreadyout_o) |-> $stable(hrdata_o))
    else $error("read data changed");
  chk_ctrl_reserved: assert property (rd_take && haddr_i[7:0] == ADDR_BACKUP_CONTROL
    |-> ##2 (hrdata_o[31:8] == 24'h0 && hrdata_o[6:3] == 4'h0 && hrdata_o[1:0] == 2'h0))
    else $error("control reserved bits set");
  chk_tick_reserved: assert property (rd_take && haddr_i[7:0] == ADDR_TICK_SELECT
    |-> ##2 hrdata_o[31:3] == 29'h0) else $error("selector reserved bits set");
  chk_unmapped_zero: assert property (rd_take && haddr_i[7:0] == 8'hFC |-> ##2 hrdata_o == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_masked: assert property (wr_take && haddr_i[7:0] == ADDR_IRQ_ENABLE
    ##1 !hwdata_i[POS_TICK_IRQ] |-> ##1 !irq_o) else $error("masked interrupt high");
  chk_irq_sticky: assert property (irq_o && !$past(wr_take) |=> irq_o)
    else $error("interrupt dropped without write");
endmodule

bind rtb_top rtb_checker #(.TICK_BASE_CYCLES(TICK_BASE_CYCLES)) rtb_checker_i (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .irq_o(irq_o));

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import rtb_pkg::*;
;
  localparam int BASE = 4;
  logic        clock_i  = 1'h0;
  logic        rst_n_i  = 1'h0;
  logic        hsel_i   = 1'h0;
  logic [31:0] haddr_i  = 32'h0;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'h0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        irq_o;
  logic [31:0] q;
  logic [31:0] v;
  int          bad_count = 0;
  int          n_checks  = 0;
  int          cyc       = 0;
  int          t0;

  always #12.5 clock_i = ~clock_i;
  always @(posedge clock_i) cyc <= cyc + 1;

  rtb_top #(.TICK_BASE_CYCLES(BASE)) rtb_top_i (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .irq_o(irq_o));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i   <= 1'h1;
    htrans_i <= 2'h2;
    hwrite_i <= w;
    haddr_i  <= {24'h0, a};
    do @(posedge clock_i); while (hreadyout_o !== 1'h1);
    hsel_i   <= 1'h0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge clock_i); while (hreadyout_o !== 1'h1);
    q = hrdata_o;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'h0, a, 32'h0);
    chk(q, exp);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    do begin
      @(posedge clock_i);
      n++;
    end while (irq_o !== 1'h1 && n < 2000);
    if (irq_o !== 1'h1) begin
      bad_count++;
      $display("ERROR at %0t: no tick interrupt within limit", $time);
    end
    t0 = cyc;
  endtask

  initial begin
    #(25 * 20000);
    bad_count++;
    wrap_up();
  end

  initial begin
    int s;
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'h1;
    @(posedge clock_i);
    rd(ADDR_BACKUP_CONTROL, RESET_BACKUP_CTRL);
    xfer(1'h1, ADDR_TICK_SELECT, 32'h3);
    rd(ADDR_TICK_SELECT, 32'h0);
    xfer(1'h1, ADDR_ACCESS_KEY, {16'h0, ACCESS_KEY});
    rd(ADDR_ACCESS_KEY, 32'h0001_0000);
    rd(ADDR_TICK_SELECT, 32'h0);
    xfer(1'h1, ADDR_TICK_SELECT, 32'hFFFF_FFFE);
    rd(ADDR_TICK_SELECT, 32'h6);
    xfer(1'h1, ADDR_ACCESS_KEY, 32'h0);
    rd(ADDR_TICK_SELECT, 32'h0);
    xfer(1'h1, ADDR_ACCESS_KEY, {16'h0, ACCESS_KEY});
    rd(ADDR_TICK_SELECT, 32'h6);
    $display("test access done");
    xfer(1'h1, ADDR_BACKUP_FIRST, 32'h1234_5678);
    rd(ADDR_BACKUP_FIRST, 32'h0);
    xfer(1'h1, ADDR_BACKUP_CONTROL, 32'hFFFF_FFFF);
    rd(ADDR_BACKUP_CONTROL, 32'h4);
    s = 0;
    do begin
      xfer(1'h0, ADDR_BACKUP_CONTROL, 32'h0);
      s++;
    end while (q[POS_UPDATE_READY] !== 1'h1 && s < 8);
    chk(q, 32'h84);
    rd(ADDR_BACKUP_FIRST, 32'h0);
    for (int i = 0; i < BACKUP_WORDS; i++) xfer(1'h1, ADDR_BACKUP_FIRST + 8'(4 * i), 32'(i + 1) * 32'h0F1E_2D3B);
    for (int i = 0; i < BACKUP_WORDS; i++) rd(ADDR_BACKUP_FIRST + 8'(4 * i), 32'(i + 1) * 32'h0F1E_2D3B);
    xfer(1'h1, ADDR_BACKUP_CONTROL, 32'h0);
    xfer(1'h1, ADDR_BACKUP_FIRST + 8'h4, 32'hDEAD_BEEF);
    rd(ADDR_BACKUP_FIRST + 8'h4, 32'h0);
    xfer(1'h1, ADDR_BACKUP_CONTROL, 32'h4);
    rd(ADDR_BACKUP_FIRST + 8'h4, 32'h1E3C_5A76);
    rd(8'hFC, 32'h0);
    chk({31'h0, hresp_o}, 32'h0);
    $display("test backup done");
    xfer(1'h1, ADDR_IRQ_ENABLE, 32'h2);
    for (int k = 0; k < 8; k++) begin
      xfer(1'h1, ADDR_TICK_SELECT, 32'(k));
      xfer(1'h1, ADDR_IRQ_STATUS, 32'h2);
      wait_irq();
      v = 32'(t0);
      xfer(1'h1, ADDR_IRQ_STATUS, 32'h2);
      wait_irq();
      chk(32'(t0) - v, 32'(BASE << (7 - k)));
    end
    xfer(1'h1, ADDR_IRQ_ENABLE, 32'h0);
    repeat (10) @(posedge clock_i);
    chk({31'h0, irq_o}, 32'h0);
    rd(ADDR_IRQ_STATUS, 32'h2);
    $display("test tick done");
    wrap_up();
  end
endmodule

`default_nettype wire
